// ===== vbi_sliced_data_packetizer.sv
// Function
// RULE1 - every packet is exactly 56 bytes including the start and end timing codes.
// RULE2 - start and end codes follow the field identity and the configured polarity and V bit.
// RULE3 - a 4-byte internal header follows the start code, carrying data type and line number.
// RULE4 - every packet ends with byte count, then checksum, then the end code.
// RULE5 - unused bytes between the last data byte and the checksum are stuffed with A0.
// RULE6 - a 35-byte MOJI line is framed exactly like any other standard.
// RULE7 - packets leave on the image port byte stream, not on a side channel.
// RULE8 - the payload region spans 44 bytes, eleven double words of data, stuffing, count and sum.
// RULE9 - the first data byte follows the last header byte with no filler in between.
`timescale 1ns/100ps
module vbi_sliced_data_packetizer
  import vbi_pkt_pkg::*;
#(
  parameter int DATA_W = 8, // slicer byte width
  parameter int DEPTH = FIFO_DEPTH // payload buffer depth
) (
  input wire logic clk_sys, // line-locked pixel clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic pkt_start, // slicer announces a line
  input wire logic [3:0] pkt_type, // recovered data type
  input wire logic [10:0] pkt_line, // video line number
  input wire logic [5:0] pkt_count, // sliced bytes this line
  input wire logic odd_even, // current field identity
  input wire logic field_invert, // config: swap field polarity
  input wire logic vbit_set, // config: V bit of timing codes
  input wire logic [7:0] sdid_cfg, // config: programmable SDID byte
  input wire logic [DATA_W-1:0] slice_data, // sliced payload byte
  input wire logic slice_valid, // payload byte offered
  output logic slice_ready, // payload buffer can take a byte
  output logic pkt_ready, // framer idle, start taken
  output logic [7:0] iport_data, // image port byte
  output logic iport_valid, // image port data qualifier
  output logic iport_sop, // first preamble byte
  output logic iport_eop // last end code byte
);
  typedef struct packed {
    phase_t ph;
    logic [5:0] pos;
    logic [5:0] cnt;
    logic fld;
    logic vb;
    logic [3:0] dtype;
    logic [10:0] line;
    logic [7:0] sdid;
    logic [7:0] sum;
    logic rdy;
    logic [7:0] odata;
    logic ovalid;
    logic osop;
    logic oeop;
    logic [5:0] opos;
  } pk_st_t;

  pk_st_t st;
  pk_st_t next_st;
  logic [7:0] b;
  logic emit;
  logic pop;

  byte_fifo_if #(.W(DATA_W)) fq ();

  // ----------------------------------------------------------------
  // payload buffer; a late slicer stalls the packet instead of padding
  // ----------------------------------------------------------------
  byte_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .f(fq.store)
  );

  assign fq.in_data = slice_data;
  assign fq.in_valid = slice_valid;
  assign fq.out_ready = pop;
  assign slice_ready = fq.in_ready;

  // ----------------------------------------------------------------
  // byte sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ovalid = 1'b0;
    next_st.osop = 1'b0;
    next_st.oeop = 1'b0;
    b = PRE_00;
    emit = 1'b0;
    pop = 1'b0;
    case (st.ph)
      PH_IDLE: begin
        next_st.rdy = 1'b1;
        if (pkt_start && st.rdy) begin
          next_st.ph = PH_SEND;
          next_st.rdy = 1'b0;
          next_st.pos = '0;
          next_st.sum = '0;
          next_st.fld = odd_even ^ field_invert; // RULE2
          next_st.vb = vbit_set; // RULE2
          next_st.sdid = sdid_cfg;
          next_st.dtype = pkt_type;
          next_st.line = pkt_line;
          // counts beyond the room before the trailer are clipped
          next_st.cnt = (pkt_count > MAX_DATA) ? MAX_DATA : pkt_count; // RULE8
        end
      end
      PH_SEND: begin
        emit = 1'b1;
        if (st.pos == '0 || st.pos == POS_EAV0) begin
          b = PRE_FF;
        end else if (st.pos < POS_TRS || (st.pos > POS_EAV0 && st.pos < POS_LAST)) begin
          b = PRE_00;
        end else if (st.pos == POS_TRS) begin
          b = trs_code(st.fld, st.vb, 1'b0); // RULE2
        end else if (st.pos == POS_SDID) begin
          b = st.sdid; // RULE3
        end else if (st.pos == POS_DC) begin
          b = DC_FIX; // RULE3
        end else if (st.pos == POS_IDA) begin
          b = {st.dtype, st.fld, st.line[10:8]}; // RULE3
        end else if (st.pos == POS_IDB) begin
          b = st.line[7:0]; // RULE3
        end else if (st.pos < POS_DATA + st.cnt) begin
          // data straight after the header; wait rather than fill
          b = fq.out_data[7:0]; // RULE9 RULE6
          pop = fq.out_valid;
          emit = fq.out_valid;
        end else if (st.pos < POS_BC) begin
          b = STUFF_BYTE; // RULE5
        end else if (st.pos == POS_BC) begin
          b = {2'b00, st.cnt}; // RULE4
        end else if (st.pos == POS_CS) begin
          b = st.sum; // RULE4
        end else begin
          b = trs_code(st.fld, st.vb, 1'b1); // RULE4 RULE2
        end
        if (emit) begin
          next_st.odata = b; // RULE7
          next_st.ovalid = 1'b1;
          next_st.opos = st.pos;
          next_st.osop = (st.pos == '0);
          next_st.oeop = (st.pos == POS_LAST);
          // sum covers header, payload, stuffing and count
          if (st.pos >= POS_SDID && st.pos <= POS_BC) begin
            next_st.sum = st.sum + b;
          end
          if (st.pos == POS_LAST) begin
            next_st.ph = PH_IDLE; // RULE1
            next_st.rdy = 1'b1;
          end else begin
            next_st.pos = st.pos + 1'b1;
          end
        end
      end
      default: begin
        next_st.ph = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '{ph: PH_IDLE, pos: '0, cnt: '0, fld: 1'b0, vb: 1'b0, dtype: '0, line: '0,
              sdid: '0, sum: '0, rdy: 1'b0, odata: '0, ovalid: 1'b0, osop: 1'b0,
              oeop: 1'b0, opos: '0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign pkt_ready = st.rdy;
  assign iport_data = st.odata;
  assign iport_valid = st.ovalid;
  assign iport_sop = st.osop;
  assign iport_eop = st.oeop;

  // ----------------------------------------------------------------
  // checks, with a byte counter kept apart from the sequencer
  // ----------------------------------------------------------------
  logic [6:0] hcnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hcnt <= '0;
    end else if (ce && st.ovalid) begin
      hcnt <= st.oeop ? 7'h00 : hcnt + 7'h01;
    end
  end

  chk_pkt_length: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    (st.ovalid && st.oeop) |-> (hcnt == 7'(PKT_LEN - 1)) && (st.opos == POS_LAST))
    else $error("packet not 56 bytes long");
  chk_sav_code: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
    (st.ovalid && st.opos == POS_TRS) |-> st.odata == {1'b1, st.fld, st.vb, 5'(0)} +
      {4'h0, st.vb, st.fld, st.fld ^ st.vb, st.fld ^ st.vb})
    else $error("start code does not match field and V bit");
  // only the first sample of byte 7 is checked: a frozen clock enable holds it for several
  chk_header_ids: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
    (st.ovalid && st.opos == POS_IDB && $past(st.opos) == POS_IDA) |->
      st.odata == st.line[7:0] && $past(st.odata) == {st.dtype, st.fld, st.line[10:8]})
    else $error("header identity bytes wrong");
  chk_trailer_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    (ce && st.ovalid && st.opos == POS_BC) |-> st.odata == {2'b00, st.cnt})
    else $error("byte count not before checksum");
  chk_end_code: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    (st.ovalid && st.oeop) |-> st.odata[7:4] == {1'b1, st.fld, st.vb, 1'b1})
    else $error("end code wrong");
  chk_stuff_fill: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    (st.ovalid && st.opos >= POS_DATA + st.cnt && st.opos < POS_BC) |-> st.odata == STUFF_BYTE)
    else $error("stuffing byte not A0");
  // independent byte counter: start preamble, start code and header plus 44 payload bytes before the end preamble
  chk_payload_span: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
    (st.ovalid && st.opos == POS_EAV0) |->
      hcnt == 7'(POS_DATA + PAYLOAD_LEN) && st.cnt <= MAX_DATA)
    else $error("payload region not 44 bytes");
  chk_moji_frame: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
    (st.ovalid && st.cnt == MOJI_DATA && st.opos == POS_DATA + MOJI_DATA) |->
      st.odata == STUFF_BYTE)
    else $error("moji line not stuffed after byte 35");
  chk_port_qual: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
    (iport_sop || iport_eop) |-> iport_valid)
    else $error("frame marker without data qualifier");
  chk_no_gap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
    (ce && st.ph == PH_SEND && st.pos == POS_DATA && st.cnt != '0) |->
      (next_st.pos == POS_DATA) || pop)
    else $error("payload start advanced without a data byte");
endmodule : vbi_sliced_data_packetizer

// ===== vbi_pkt_pkg.sv
package vbi_pkt_pkg;
  // ----------------------------------------------------------------
  // packet geometry, byte positions counted from the first preamble
  // ----------------------------------------------------------------
  localparam int unsigned PKT_LEN = 56;
  localparam logic [5:0] POS_TRS = 6'h03;
  localparam logic [5:0] POS_SDID = 6'h04;
  localparam logic [5:0] POS_DC = 6'h05;
  localparam logic [5:0] POS_IDA = 6'h06;
  localparam logic [5:0] POS_IDB = 6'h07;
  localparam logic [5:0] POS_DATA = 6'h08;
  localparam logic [5:0] POS_BC = 6'h32;
  localparam logic [5:0] POS_CS = 6'h33;
  localparam logic [5:0] POS_EAV0 = 6'h34;
  localparam logic [5:0] POS_LAST = 6'h37;
  localparam logic [5:0] PAYLOAD_LEN = 6'h2C;
  localparam logic [5:0] MAX_DATA = 6'h2A;
  localparam logic [5:0] MOJI_DATA = 6'h23;
  localparam int unsigned FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // fixed byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] PRE_FF = 8'hFF;
  localparam logic [7:0] PRE_00 = 8'h00;
  localparam logic [7:0] STUFF_BYTE = 8'hA0;
  localparam logic [7:0] DC_FIX = 8'h0B;

  typedef enum logic {PH_IDLE, PH_SEND} phase_t;

  // timing reference code: 1 F V H with four protection bits
  function automatic logic [7:0] trs_code(input logic f, input logic v, input logic h);
    trs_code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction : trs_code
endpackage : vbi_pkt_pkg

// ===== byte_fifo_if.sv
`timescale 1ns/100ps
interface byte_fifo_if #(parameter int W = 8);
  logic [W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport store (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface : byte_fifo_if

// ===== byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  byte_fifo_if.store f // fill and drain sides
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [AW-1:0] PTR_TOP = AW'(D - 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
  } fifo_st_t;

  fifo_st_t st;
  fifo_st_t next_st;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // head word comes straight out of the storage registers
  // ----------------------------------------------------------------
  assign f.out_data = st.mem[st.rp];
  assign f.out_valid = (st.cnt != '0);
  assign f.in_ready = st.rdy;

  // pointer wrap kept explicit so depth need not be a power of two
  always_comb begin
    next_st = st;
    push = f.in_valid && st.rdy;
    pop = f.out_ready && (st.cnt != '0);
    if (push) begin
      next_st.mem[st.wp] = f.in_data;
      next_st.wp = (st.wp == PTR_TOP) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == PTR_TOP) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.rdy = (next_st.cnt != CNT_FULL); // registered so the top port comes from a flop
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else if (ce) begin
      st <= next_st;
    end
  end

  chk_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.cnt <= CNT_FULL && (st.rdy == (st.cnt != CNT_FULL)))
    else $error("fifo count out of range or ready wrong");
endmodule : byte_fifo

// ===== iport_sink.sv
`timescale 1ns/100ps
module iport_sink (
  input wire logic clk_sys, // pixel clock
  input wire logic ce, // clock enable
  input wire logic iport_valid, // byte qualifier
  input wire logic iport_sop, // first byte flag
  input wire logic iport_eop, // last byte flag
  input wire logic [7:0] iport_data // image port byte
);
  logic [7:0] rx [0:63];
  logic [63:0] sop_map = '0;
  logic [63:0] eop_map = '0;
  int n = 0;
  int pkts = 0;
  // ----------------------------------------------------------------
  // capture side of the image port
  // ----------------------------------------------------------------
  // sampled mid-cycle so registered outputs have settled before the taking edge
  always @(negedge clk_sys) begin
    if (ce && iport_valid) begin
      if (iport_sop) begin
        n = 0;
        sop_map = '0;
        eop_map = '0;
      end
      rx[n[5:0]] = iport_data;
      sop_map[n[5:0]] = iport_sop;
      eop_map[n[5:0]] = iport_eop;
      n++;
      if (iport_eop) pkts++;
    end
  end
endmodule : iport_sink

// ===== testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import vbi_pkt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic ce_rand = 1'b0;
  logic pkt_start = 1'b0;
  logic [3:0] pkt_type = 4'h0;
  logic [10:0] pkt_line = 11'h000;
  logic [5:0] pkt_count = 6'h00;
  logic odd_even = 1'b0, field_invert = 1'b0, vbit_set = 1'b0;
  logic [7:0] sdid_cfg = 8'h00;
  logic [7:0] slice_data = 8'h00;
  logic slice_valid = 1'b0;
  logic slice_ready, pkt_ready, iport_valid, iport_sop, iport_eop;
  logic [7:0] iport_data;
  logic [7:0] exp_b [0:55];
  logic [7:0] pay [0:41];
  logic [5:0] corner [5] = '{6'h2A, 6'h23, 6'h00, 6'h01, 6'h2D};
  integer seed = 32'h1C09;
  int error_cnt = 0;
  int total_checks = 0;

  vbi_sliced_data_packetizer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .pkt_start(pkt_start), .pkt_type(pkt_type), .pkt_line(pkt_line), .pkt_count(pkt_count),
    .odd_even(odd_even), .field_invert(field_invert), .vbit_set(vbit_set),
    .sdid_cfg(sdid_cfg), .slice_data(slice_data), .slice_valid(slice_valid),
    .slice_ready(slice_ready), .pkt_ready(pkt_ready), .iport_data(iport_data),
    .iport_valid(iport_valid), .iport_sop(iport_sop), .iport_eop(iport_eop));
  iport_sink sink_u (.clk_sys(clk_sys), .ce(ce), .iport_valid(iport_valid),
    .iport_sop(iport_sop), .iport_eop(iport_eop), .iport_data(iport_data));

  // ----------------------------------------------------------------
  // clock, random clock enable, expectation helpers
  // ----------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  // frozen cycles in mid-packet catch bytes counted on dead edges
  always @(posedge clk_sys) ce <= !ce_rand || (($random(seed) & 7) != 0);

  function automatic logic [7:0] trs(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction : trs

  task automatic build(input logic [5:0] c);
    logic f;
    logic [7:0] s;
    f = odd_even ^ field_invert;
    exp_b[0] = 8'hFF;
    exp_b[1] = 8'h00;
    exp_b[2] = 8'h00;
    exp_b[3] = trs(f, vbit_set, 1'b0);
    exp_b[4] = sdid_cfg;
    exp_b[5] = 8'h0B;
    exp_b[6] = {pkt_type, f, pkt_line[10:8]};
    exp_b[7] = pkt_line[7:0];
    for (int i = 8; i < 50; i++) exp_b[i] = (i - 8 < c) ? pay[i - 8] : 8'hA0;
    exp_b[50] = {2'b00, c};
    s = 8'h00;
    for (int i = 4; i < 51; i++) s += exp_b[i];
    exp_b[51] = s;
    exp_b[52] = 8'hFF;
    exp_b[53] = 8'h00;
    exp_b[54] = 8'h00;
    exp_b[55] = trs(f, vbit_set, 1'b1);
  endtask : build

  // hold the request until an edge with ce and ready both high takes it
  task automatic feed(input int c);
    logic ok;
    int g;
    for (int k = 0; k < c; k++) begin
      g = $random(seed) & 3;
      if (g != 0) begin
        slice_valid <= 1'b0;
        repeat (g) @(posedge clk_sys);
      end
      slice_data <= pay[k];
      slice_valid <= 1'b1;
      do begin
        @(negedge clk_sys);
        ok = ce && slice_ready;
        @(posedge clk_sys);
      end while (!ok);
    end
    slice_valid <= 1'b0;
  endtask : feed

  task automatic start_pkt(input logic [5:0] cl);
    logic ok;
    repeat (20) @(posedge clk_sys);
    // payload pushed ahead of the start must have filled the buffer
    if (cl > 6'h04 && !ce_rand) `CHK("slice_ready", 1'b0, slice_ready)
    pkt_start <= 1'b1;
    do begin
      @(negedge clk_sys);
      ok = ce && pkt_ready;
      @(posedge clk_sys);
    end while (!ok);
    pkt_start <= 1'b0;
  endtask : start_pkt

  task automatic run_pkt(input logic [5:0] c);
    logic [5:0] cl;
    int p0;
    cl = (c > 6'h2A) ? 6'h2A : c;
    for (int k = 0; k < 42; k++) pay[k] = 8'($random(seed));
    pkt_type <= 4'($random(seed));
    pkt_line <= 11'($random(seed));
    pkt_count <= c;
    {odd_even, field_invert, vbit_set} <= 3'($random(seed));
    sdid_cfg <= 8'($random(seed));
    @(posedge clk_sys);
    build(cl);
    p0 = sink_u.pkts;
    fork
      feed(cl);
      start_pkt(cl);
    join
    for (int t = 0; t < 1000 && sink_u.pkts == p0; t++) @(posedge clk_sys);
    `CHK("packets", p0 + 1, sink_u.pkts)
    `CHK("length", 56, sink_u.n)
    `CHK("marks", {64'h1 << 55, 64'h1}, {sink_u.eop_map, sink_u.sop_map})
    for (int i = 0; i < 56; i++)
      `CHK("byte", exp_b[i], sink_u.rx[i])
  endtask : run_pkt

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("reset", 3'b010, {pkt_ready, slice_ready, iport_valid})
    @(posedge clk_sys);
    rst_n <= 1'b1;
    // full, MOJI, empty, single and clipped payloads first
    foreach (corner[j]) run_pkt(corner[j]);
    ce_rand <= 1'b1;
    repeat (12) run_pkt(6'($unsigned($random(seed)) % 43));
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
endmodule : testbench
